// ==== hdl/usb_status_pkg.sv ====
// Purpose: Shared constants for the USB function status register bank.
// Assumes: Byte-wide registers on a byte-addressed microcontroller bus.
// Notes:   Offsets are the full 16-bit external data addresses.
package usb_status_pkg;

  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;

  localparam logic [15:0] OFS_INT_ENABLE  = 16'hfffd;
  localparam logic [15:0] OFS_EVENT_FLAGS = 16'hfffe;
  localparam logic [15:0] OFS_DEV_ADDRESS = 16'hffff;
  localparam logic [15:0] OFS_CONTROL     = 16'hfffc;
  localparam logic [15:0] OFS_INT_VECTOR  = 16'hffb2;

  localparam logic [7:0]  RST_INT_ENABLE  = 8'h00;
  localparam logic [7:0]  RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0]  RST_DEV_ADDRESS = 8'h00;
  localparam logic [7:0]  RST_CONTROL     = 8'h00;

  // Field positions in the flags and enable registers.
  localparam int          BIT_BUS_RESET   = 7;
  localparam int          BIT_SUSPEND     = 6;
  localparam int          BIT_RESUME      = 5;
  localparam int          BIT_FRAME       = 4;
  localparam int          BIT_ART_FRAME   = 3;
  localparam int          BIT_SETUP       = 2;
  localparam int          BIT_SETUP_OVWR  = 0;
  localparam logic [7:0]  FLAG_MASK       = 8'hfd;
  localparam logic [7:0]  ADDR_MASK       = 8'h7f;

  // Field positions in the control register.
  localparam int          BIT_CONNECT     = 7;
  localparam int          BIT_FUNC_EN     = 6;
  localparam int          BIT_WAKEUP      = 5;
  localparam int          BIT_RST_PROP    = 4;
  localparam logic [7:0]  CTRL_MASK       = 8'hf0;

endpackage

// ==== hdl/usb_function_status_regs.sv ====
// Purpose: USB function address, event flags, interrupt enable and control.
// Assumes: Event inputs are one-cycle pulses on REF_CLK from the engine.
// Notes:   Bus reset pulse comes from the engine on the same clock.
// Functional notes
// - The address register holds a writable seven-bit device address.
// - The device address returns to zero on power-on and USB bus reset.
// - A USB bus reset sets the bus reset flag.
// - A USB bus reset resets engine, buffer manager, timer and suspend logic.
// - With propagation enabled, bus reset also drives the reset output pin.
// - Flags are read-only; any interrupt vector write clears all but same-cycle events.
// - A detected suspend condition sets the suspend flag.
// - A detected resume condition sets the resume flag.
// - Every received start-of-frame sets the frame flag.
// - An artificial start-of-frame sets the artificial frame flag.
// - A completed setup transaction sets the setup flag.
// - An overwritten setup buffer sets the setup overwrite flag.
// - Each flag has an enable bit, reset to zero, gating its interrupt.
// - Address bit 7 and flag and enable bit 1 read as zero.
// - Bus reset clears function enable and keeps connect and propagation.
`timescale 1ns/1ps

module usb_function_status_regs
  import usb_status_pkg::*;
(
  // Clock and power-on reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // Microcontroller register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic              WR,
  input  wire logic              RD,
  input  wire logic [DATA_W-1:0] WDATA,
  output logic      [DATA_W-1:0] RDATA,
  // Events from the serial engine and frame timer
  input  wire logic              BUS_RESET,
  input  wire logic              SUSPEND_DET,
  input  wire logic              RESUME_DET,
  input  wire logic              FRAME_RCVD,
  input  wire logic              ART_FRAME,
  input  wire logic              SETUP_DONE,
  input  wire logic              SETUP_OVWR,
  // Status outputs
  output logic      [6:0]        DEVICE_ADDRESS,
  output logic                   USB_INT,
  output logic                   USB_LOGIC_RESET,
  output logic                   SYSTEM_RESET,
  output logic                   RESET_OUTPUT_PIN,
  output logic                   FUNCTION_ENABLE,
  output logic                   CONNECT,
  output logic                   REMOTE_WAKEUP
);

  logic [7:0] address_r, address_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] enable_r, enable_nxt;
  logic [7:0] control_r, control_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] events;

  wire sel_addr = (ADDR == OFS_DEV_ADDRESS);
  wire sel_flag = (ADDR == OFS_EVENT_FLAGS);
  wire sel_en   = (ADDR == OFS_INT_ENABLE);
  wire sel_ctrl = (ADDR == OFS_CONTROL);
  wire sel_vec  = (ADDR == OFS_INT_VECTOR);
  wire prop_on  = control_r[BIT_RST_PROP];

  // Event vector in flag bit order; bit 1 stays empty.
  assign events = {BUS_RESET, SUSPEND_DET, RESUME_DET, FRAME_RCVD,
                   ART_FRAME, SETUP_DONE, 1'b0, SETUP_OVWR};

  // A bus reset outranks a software address write in the same cycle.
  assign address_nxt = BUS_RESET ? RST_DEV_ADDRESS
                     : (WR && sel_addr) ? (WDATA & ADDR_MASK)
                     : address_r;

  // New events win over a vector-write clear so none is lost.
  assign flags_nxt = (((WR && sel_vec) ? 8'h00 : flags_r) | events)
                     & FLAG_MASK;

  assign enable_nxt = (WR && sel_en) ? (WDATA & FLAG_MASK)
                    : enable_r;

  // Connect and propagation bits survive a bus reset; enable does not.
  always_comb begin
    control_nxt = control_r;
    if (WR && sel_ctrl) begin
      control_nxt = WDATA & CTRL_MASK;
    end
    if (BUS_RESET) begin
      control_nxt[BIT_FUNC_EN] = 1'b0;
    end
  end

  assign rdata_nxt = sel_addr ? address_r
                   : sel_flag ? flags_r
                   : sel_en   ? enable_r
                   : sel_ctrl ? control_r
                   : 8'h00;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      address_r <= RST_DEV_ADDRESS;
      flags_r   <= RST_EVENT_FLAGS;
      enable_r  <= RST_INT_ENABLE;
      control_r <= RST_CONTROL;
    end else begin
      address_r <= address_nxt;
      flags_r   <= flags_nxt;
      enable_r  <= enable_nxt;
      control_r <= control_nxt;
    end
  end

  // Outputs are registered; they trail the register state by one cycle
  // except the reset fan-out, which trails the bus reset pulse itself by one cycle.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RDATA            <= 8'h00;
      DEVICE_ADDRESS   <= 7'h00;
      USB_INT          <= 1'b0;
      USB_LOGIC_RESET  <= 1'b0;
      SYSTEM_RESET     <= 1'b0;
      RESET_OUTPUT_PIN <= 1'b0;
      FUNCTION_ENABLE  <= 1'b0;
      CONNECT          <= 1'b0;
      REMOTE_WAKEUP    <= 1'b0;
    end else begin
      RDATA            <= RD ? rdata_nxt : 8'h00;
      DEVICE_ADDRESS   <= address_r[6:0];
      USB_INT          <= |(flags_r & enable_r);
      USB_LOGIC_RESET  <= BUS_RESET;
      SYSTEM_RESET     <= BUS_RESET && prop_on;
      RESET_OUTPUT_PIN <= BUS_RESET && prop_on;
      FUNCTION_ENABLE  <= control_r[BIT_FUNC_EN];
      CONNECT          <= control_r[BIT_CONNECT];
      REMOTE_WAKEUP    <= control_r[BIT_WAKEUP];
    end
  end

  // Checks.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  logic past_valid_r;
  always_ff @(posedge REF_CLK) begin
    past_valid_r <= !RST;
  end

  addr_reset_zero_a: assert property (BUS_RESET |=> address_r == 8'h00)
    else $error("address not cleared by bus reset");
  addr_write_a: assert property (WR && sel_addr && !BUS_RESET |=>
      address_r == ($past(WDATA) & 8'h7f))
    else $error("address write lost");
  addr_out_a: assert property (past_valid_r |=> DEVICE_ADDRESS ==
      $past(address_r[6:0]))
    else $error("address output stale");
  reset_flag_a: assert property (BUS_RESET |=> flags_r[7])
    else $error("bus reset flag not set");
  suspend_flag_a: assert property (SUSPEND_DET |=> flags_r[6])
    else $error("suspend flag not set");
  resume_flag_a: assert property (RESUME_DET |=> flags_r[5])
    else $error("resume flag not set");
  frame_flag_a: assert property (FRAME_RCVD |=> flags_r[4])
    else $error("frame flag not set");
  art_flag_a: assert property (ART_FRAME |=> flags_r[3])
    else $error("artificial frame flag not set");
  setup_flag_a: assert property (SETUP_DONE |=> flags_r[2])
    else $error("setup flag not set");
  ovwr_flag_a: assert property (SETUP_OVWR |=> flags_r[0])
    else $error("overwrite flag not set");
  vector_clear_a: assert property (WR && sel_vec && events == 8'h00
      |=> flags_r == 8'h00)
    else $error("flags not cleared by vector write");
  flags_hold_a: assert property (!(WR && sel_vec) && events == 8'h00
      |=> flags_r == $past(flags_r))
    else $error("flags changed without cause");
  reserved_zero_a: assert property (!flags_r[1] && !enable_r[1]
      && !address_r[7])
    else $error("reserved bit set");
  int_gate_a: assert property (past_valid_r |=> USB_INT ==
      |($past(flags_r) & $past(enable_r)))
    else $error("interrupt gating wrong");
  pin_reset_a: assert property (BUS_RESET && prop_on |=>
      RESET_OUTPUT_PIN && SYSTEM_RESET && USB_LOGIC_RESET)
    else $error("reset pin not driven");
  func_en_clr_a: assert property (BUS_RESET |=>
      !control_r[6] && control_r[7] == $past(control_r[7])
      && control_r[4] == $past(control_r[4]))
    else $error("control bits wrong after bus reset");


  // Read port. RDATA is a registered copy of the selected register, and
  // it falls back to zero whenever no read was strobed, so a bus that
  // ORs several slaves together sees nothing from this bank when idle.

  rdata_flags_a: assert property (RD && sel_flag |=>
      RDATA == $past(flags_r))
    else $error("flags read data wrong");

  rdata_addr_a: assert property (RD && sel_addr |=>
      RDATA == $past(address_r))
    else $error("address read data wrong");

  rdata_enable_a: assert property (RD && sel_en |=>
      RDATA == $past(enable_r))
    else $error("enable read data wrong");

  rdata_ctrl_a: assert property (RD && sel_ctrl |=>
      RDATA == $past(control_r))
    else $error("control read data wrong");

  rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not idle");

  rdata_unmapped_a: assert property (RD && !sel_addr && !sel_flag
      && !sel_en && !sel_ctrl |=> RDATA == 8'h00)
    else $error("unmapped read not zero");

  // Flags. A write to the flags register itself must change nothing,
  // since software may only clear them through the vector register.

  flags_ro_a: assert property (WR && sel_flag && events == 8'h00
      |=> flags_r == $past(flags_r))
    else $error("flags written by software");

  // An event arriving in the clearing cycle survives the clear, so a
  // frame marker landing just as software clears is never dropped.

  set_wins_a: assert property (WR && sel_vec |=>
      flags_r == ($past(events) & 8'hfd))
    else $error("event lost to vector clear");

  // Interrupt enable register.

  enable_write_a: assert property (WR && sel_en |=>
      enable_r == ($past(WDATA) & 8'hfd))
    else $error("enable write lost");

  enable_hold_a: assert property (!(WR && sel_en) |=>
      enable_r == $past(enable_r))
    else $error("enable changed without write");

  int_low_a: assert property ((flags_r & enable_r) == 8'h00 |=>
      !USB_INT)
    else $error("interrupt without enabled flag");

  // Device address register.

  addr_hold_a: assert property (!BUS_RESET && !(WR && sel_addr)
      |=> address_r == $past(address_r))
    else $error("address changed without cause");

  // Control register. Its low nibble is reserved and must stay clear.

  ctrl_write_a: assert property (WR && sel_ctrl && !BUS_RESET |=>
      control_r == ($past(WDATA) & 8'hf0))
    else $error("control write lost");

  ctrl_low_zero_a: assert property (control_r[3:0] == 4'h0)
    else $error("control reserved bits set");

  ctrl_out_a: assert property (past_valid_r |=>
      FUNCTION_ENABLE == $past(control_r[6])
      && CONNECT == $past(control_r[7])
      && REMOTE_WAKEUP == $past(control_r[5]))
    else $error("control outputs stale");

  // Reset fan-out. USB_LOGIC_RESET is a single registered copy of the bus
  // reset pulse, the two pin outputs only while propagation is on; a
  // downstream block that needs a longer reset must stretch it itself.

  logic_rst_a: assert property (past_valid_r |=>
      USB_LOGIC_RESET == $past(BUS_RESET))
    else $error("logic reset does not follow bus reset");

  pin_quiet_a: assert property (!prop_on |=>
      !RESET_OUTPUT_PIN && !SYSTEM_RESET)
    else $error("reset pin driven while propagation off");

  // Main scenarios worth seeing at least once.

  int_cov: cover property (SETUP_DONE && enable_r[2] ##2 USB_INT);
  clash_cov: cover property (WR && sel_vec && events != 8'h00);
  clear_cov: cover property (flags_r != 8'h00 && WR && sel_vec);
  reset_cov: cover property (BUS_RESET && prop_on);
  addr_cov: cover property (WR && sel_addr ##1 address_r != 8'h00);

endmodule // usb_function_status_regs

// ==== dv/usb_engine_model.sv ====
// Purpose: Serial engine and frame timer stand-in that raises USB events.
// Assumes: Bench sets one request bit per event, one cycle ahead.
// Notes:   Request bits follow the flag positions; bit 1 is never used.
`timescale 1ns/1ps

module usb_engine_model (
  // Clock
  input  wire logic       clk,
  // Requests from the bench
  input  wire logic [7:0] req,
  // Event pulses toward the register bank
  output logic            bus_reset,
  output logic            suspend,
  output logic            resume,
  output logic            frame,
  output logic            art_frame,
  output logic            setup_done,
  output logic            setup_ovwr
);
  logic [7:0] pulse_r;

  // Registered so every event is a clean one-cycle pulse on the clock.
  always_ff @(posedge clk) begin
    pulse_r <= req;
  end

  assign bus_reset  = pulse_r[7];
  assign suspend    = pulse_r[6];
  assign resume     = pulse_r[5];
  assign frame      = pulse_r[4];
  assign art_frame  = pulse_r[3];
  assign setup_done = pulse_r[2];
  assign setup_ovwr = pulse_r[0];
endmodule // usb_engine_model

// ==== dv/usb_function_status_regs_tb.sv ====
// Purpose: Self-checking bench for the USB function status registers.
// Assumes: Events reach the bank one cycle after a model request.
// Notes:   Expected values come from the package constants and fixed literals.
`timescale 1ns/1ps

module usb_function_status_regs_tb
  import usb_status_pkg::*;
;
  logic        clk, rst, wr, rd, brst, susp, resm, frm, art, stp, ovw;
  logic        irq, lrst, srst, rpin, function_enable_bit, conn, wake;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, req, d, en;
  logic [6:0]  dadr;
  int          error_cnt, tests_run, seed;

  usb_function_status_regs dut (
    .REF_CLK(clk), .RST(rst), .ADDR(addr), .WR(wr), .RD(rd),
    .WDATA(wdata), .RDATA(rdata), .BUS_RESET(brst), .SUSPEND_DET(susp),
    .RESUME_DET(resm), .FRAME_RCVD(frm), .ART_FRAME(art),
    .SETUP_DONE(stp), .SETUP_OVWR(ovw), .DEVICE_ADDRESS(dadr),
    .USB_INT(irq), .USB_LOGIC_RESET(lrst), .SYSTEM_RESET(srst),
    .RESET_OUTPUT_PIN(rpin), .FUNCTION_ENABLE(function_enable_bit), .CONNECT(conn),
    .REMOTE_WAKEUP(wake)
  );

  usb_engine_model host (
    .clk(clk), .req(req), .bus_reset(brst), .suspend(susp),
    .resume(resm), .frame(frm), .art_frame(art), .setup_done(stp),
    .setup_ovwr(ovw)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic irq_exp(input logic [7:0] f, input logic [7:0] e);
    return |(f & e & FLAG_MASK);
  endfunction

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    v = rdata;
  endtask

  // Returns on the edge where the design takes the event.
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    #1 req = m;
    @(posedge clk);
    #1 req = 8'h00;
    @(posedge clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    seed = 84359;
    {rst, wr, rd, addr, wdata, req} = {1'b1, 34'h0};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd_reg(OFS_INT_ENABLE, d);
    chk("enable", RST_INT_ENABLE, d);
    rd_reg(OFS_EVENT_FLAGS, d);
    chk("flags", RST_EVENT_FLAGS, d);
    rd_reg(16'hff00, d);
    chk("unmapped", 8'h00, d);
    repeat (3) begin
      en = 8'($random(seed));
      wr_reg(OFS_DEV_ADDRESS, en | 8'h80);
      @(posedge clk);
      #1 chk("addr pins", en & ADDR_MASK, {1'b0, dadr});
      rd_reg(OFS_DEV_ADDRESS, d);
      chk("address", en & ADDR_MASK, d);
    end
    for (int i = 0; i < 8; i++) begin
      if (i != 1) begin
        en = 8'($random(seed));
        wr_reg(OFS_INT_ENABLE, en);
        wr_reg(OFS_EVENT_FLAGS, 8'hff);
        pulse(8'h01 << i);
        rd_reg(OFS_EVENT_FLAGS, d);
        chk("flags", 8'h01 << i, d);
        chk("irq", {7'h00, irq_exp(8'h01 << i, en)}, {7'h00, irq});
        rd_reg(OFS_INT_ENABLE, d);
        chk("enable", en & FLAG_MASK, d);
        wr_reg(OFS_INT_VECTOR, 8'h00);
        rd_reg(OFS_EVENT_FLAGS, d);
        chk("cleared", 8'h00, d);
        chk("irq off", 8'h00, {7'h00, irq});
      end
    end
    wr_reg(OFS_CONTROL, 8'hff);
    wr_reg(OFS_DEV_ADDRESS, 8'h2a);
    pulse(8'h80);
    #1 chk("resets", 8'h07, {5'h00, lrst, srst, rpin});
    rd_reg(OFS_DEV_ADDRESS, d);
    chk("address", 8'h00, d);
    chk("addr pins", 8'h00, {1'b0, dadr});
    rd_reg(OFS_CONTROL, d);
    chk("control", 8'hb0, d);
    chk("ctl pins", 8'h03, {5'h00, function_enable_bit, conn, wake});
    wr_reg(OFS_CONTROL, 8'h80);
    pulse(8'h80);
    #1 chk("resets", 8'h04, {5'h00, lrst, srst, rpin});
    end_sim();
  end
endmodule // usb_function_status_regs_tb
